// *** sse_terminus.sv ***
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "sse_params.svh"
// Function
// R1 - Handles 0x0000 and 0xFFFF identify no effecter
// R2 - Set count 1..8 addresses offsets 0 upward
// R3 - Count records follow, code then target byte
// R4 - No-change record leaves effecter untouched
// R5 - Request-set record drives effecter toward target
// R6 - Targets checked against effecter state set
// R7 - Unknown handle on set answers 0x80
// R8 - Target outside state set answers 0x81
// R9 - Illegal operational state target answers 0x82
// R10 - Get request carries only the handle
// R11 - Get answer: code, count, count records
// R12 - Unknown handle on get answers 0x80
// R13 - Record: operational, pending, present state bytes
// R14 - Unknown state unless operational state enabled
// R15 - Disabled effecter accepts no state update
// R16 - Set code 0 no change, 1 set
// R17 - Failed set returns code only, changes nothing
module sse_terminus (
   input wire logic clk,
   input wire logic rst_n,
   sse_link_if.term link,
   input wire logic [7:0] eff_disable,
   input wire logic [7:0] eff_unavail,
   output logic [63:0] eff_present,
   output logic [7:0] eff_pending,
   output logic [7:0] eff_apply
);
   // ------
   // Request capture
   // ------
   sse_pkg::sse_tstate_t state;
   logic [7:0] rx_buf [0:`SSE_RX_MAX-1];
   logic [4:0] rx_cnt;
   logic rx_ovf;
   logic [7:0] cc;
   logic set_ok;
   logic [4:0] tx_idx, tx_len;
   logic [7:0] next_cc;
   logic [7:0] next_wmask;
   logic [7:0] tgt [0:`SSE_EFF_NUM-1];
   logic [7:0] present [0:`SSE_EFF_NUM-1];

   function automatic sse_pkg::sse_op_t op_of(input logic dis,
      input logic unav, input logic pend);
      if (unav) begin
         return sse_pkg::SSE_OP_UNAVAIL;
      end else if (dis) begin
         return sse_pkg::SSE_OP_DISABLED;
      end else if (pend) begin
         return sse_pkg::SSE_OP_UPD_PEND;
      end
      return sse_pkg::SSE_OP_NO_UPD;
   endfunction

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_cnt <= 5'h00;
         rx_ovf <= 1'b0;
         for (int i = 0; i < `SSE_RX_MAX; i++) begin
            rx_buf[i] <= 8'h00;
         end
      end else if (link.req_valid && state == sse_pkg::SSE_T_IDLE) begin
         rx_buf[0] <= link.req_data;
         rx_cnt <= 5'h01;
         rx_ovf <= 1'b0;
      end else if (link.req_valid && state == sse_pkg::SSE_T_RX) begin
         if (rx_cnt < 5'(`SSE_RX_MAX)) begin
            rx_buf[rx_cnt] <= link.req_data;
            rx_cnt <= rx_cnt + 5'h01;
         end else begin
            rx_ovf <= 1'b1;
         end
      end
   end

   // ------
   // Request check
   // ------
   always_comb begin
      logic [15:0] hdl;
      logic [7:0] cnt;
      logic is_set, is_get, len_ok, code_bad, st_bad, op_bad;
      sse_pkg::sse_op_t op;
      hdl = {rx_buf[2], rx_buf[1]};
      cnt = rx_buf[3];
      is_set = rx_buf[0] == `SSE_CMD_SET;
      is_get = rx_buf[0] == `SSE_CMD_GET;
      code_bad = 1'b0;
      st_bad = 1'b0;
      op_bad = 1'b0;
      next_wmask = 8'h00;
      len_ok = !rx_ovf && rx_cnt == 5'd3; // R10
      op = sse_pkg::SSE_OP_NO_UPD;
      if (!is_get) begin
         len_ok = !rx_ovf && cnt >= `SSE_CNT_MIN && cnt <= `SSE_CNT_MAX
                  && rx_cnt == 5'(5'd4 + {cnt[3:0], 1'b0}); // R2 R3
      end
      for (int i = 0; i < `SSE_EFF_NUM; i++) begin
         op = op_of(eff_disable[i], eff_unavail[i], eff_pending[i]);
         if (8'(i) < cnt) begin
            if (rx_buf[4 + 2 * i] == `SSE_SR_REQ_SET) begin // R5
               if (rx_buf[5 + 2 * i] < `SSE_ST_MIN ||
                   rx_buf[5 + 2 * i] > `SSE_ST_MAX) begin
                  st_bad = 1'b1; // R6
               end
               if (op == sse_pkg::SSE_OP_DISABLED ||
                   op == sse_pkg::SSE_OP_UNAVAIL) begin
                  op_bad = 1'b1; // R15
               end
               next_wmask[i] = 1'b1;
            end else if (rx_buf[4 + 2 * i] != `SSE_SR_NO_CHANGE) begin // R4
               code_bad = 1'b1; // R16
            end
         end
      end
      if (!is_set && !is_get) begin
         next_cc = `SSE_CC_BAD_CMD;
      end else if (hdl == `SSE_HDL_RSVD_LO || hdl == `SSE_HDL_RSVD_HI ||
                   hdl != `SSE_HDL_OWN) begin
         next_cc = `SSE_CC_INV_ID; // R1 R7 R12
      end else if (!len_ok || (is_set && code_bad)) begin
         next_cc = `SSE_CC_INV_DATA;
      end else if (is_set && st_bad) begin
         next_cc = `SSE_CC_INV_STATE; // R8
      end else if (is_set && op_bad) begin
         next_cc = `SSE_CC_UNSUP_STATE; // R9
      end else begin
         next_cc = `SSE_CC_SUCCESS;
      end
      if (!is_set || next_cc != `SSE_CC_SUCCESS) begin
         next_wmask = 8'h00; // R17
      end
   end

   // ------
   // Control sequence
   // ------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= sse_pkg::SSE_T_IDLE;
         cc <= `SSE_CC_SUCCESS;
         set_ok <= 1'b0;
         tx_idx <= 5'h00;
         tx_len <= 5'h01;
      end else begin
         set_ok <= 1'b0;
         unique case (state)
            sse_pkg::SSE_T_IDLE: begin
               if (link.req_valid) begin
                  state <= link.req_last ? sse_pkg::SSE_T_EVAL
                                         : sse_pkg::SSE_T_RX;
               end
            end
            sse_pkg::SSE_T_RX: begin
               if (link.req_valid && link.req_last) begin
                  state <= sse_pkg::SSE_T_EVAL;
               end
            end
            sse_pkg::SSE_T_EVAL: begin
               cc <= next_cc;
               set_ok <= |next_wmask;
               tx_idx <= 5'h00;
               if (rx_buf[0] == `SSE_CMD_GET && next_cc == `SSE_CC_SUCCESS)
               begin
                  tx_len <= 5'(`SSE_GET_RSP_LEN); // R11
               end else begin
                  tx_len <= 5'h01; // R17
               end
               state <= sse_pkg::SSE_T_TX;
            end
            sse_pkg::SSE_T_TX: begin
               tx_idx <= tx_idx + 5'h01;
               if (tx_idx == tx_len - 5'h01) begin
                  state <= sse_pkg::SSE_T_IDLE;
               end
            end
         endcase
      end
   end

   // ------
   // Effecters
   // ------
   logic [7:0] wmask;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wmask <= 8'h00;
      end else if (state == sse_pkg::SSE_T_EVAL) begin
         wmask <= next_wmask;
      end
   end

   // The update delay stands in for the physical effecter settling.
   for (genvar g = 0; g < `SSE_EFF_NUM; g++) begin : g_eff
      logic [7:0] wait_cnt;
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            tgt[g] <= `SSE_ST_RESET;
            present[g] <= `SSE_ST_RESET;
            wait_cnt <= 8'h00;
            eff_pending[g] <= 1'b0;
            eff_apply[g] <= 1'b0;
         end else begin
            eff_apply[g] <= 1'b0;
            if (set_ok && wmask[g]) begin
               tgt[g] <= rx_buf[5 + 2 * g]; // R5
               wait_cnt <= 8'(`SSE_UPD_CYC);
               eff_pending[g] <= 1'b1;
            end else if (eff_pending[g] &&
               (eff_disable[g] || eff_unavail[g])) begin
               eff_pending[g] <= 1'b0; // R15
            end else if (eff_pending[g]) begin
               wait_cnt <= wait_cnt - 8'h01;
               if (wait_cnt == 8'h01) begin
                  present[g] <= tgt[g];
                  eff_pending[g] <= 1'b0;
                  eff_apply[g] <= 1'b1;
               end
            end
         end
      end
      assign eff_present[8 * g +: 8] = present[g];
   end

   // ------
   // Response
   // ------
   logic [7:0] tx_byte;

   always_comb begin
      logic [4:0] r, f;
      sse_pkg::sse_op_t op;
      r = (tx_idx - 5'd2) / 5'd3;
      f = (tx_idx - 5'd2) % 5'd3;
      op = op_of(eff_disable[r[2:0]], eff_unavail[r[2:0]],
                 eff_pending[r[2:0]]);
      if (tx_idx == 5'd0) begin
         tx_byte = cc;
      end else if (tx_idx == 5'd1) begin
         tx_byte = 8'(`SSE_EFF_NUM); // R11
      end else if (f == 5'd0) begin
         tx_byte = op; // R13
      end else if (op != sse_pkg::SSE_OP_UPD_PEND &&
                   op != sse_pkg::SSE_OP_NO_UPD) begin
         tx_byte = `SSE_ST_UNKNOWN; // R14
      end else if (f == 5'd1 && op == sse_pkg::SSE_OP_UPD_PEND) begin
         tx_byte = tgt[r[2:0]]; // R13
      end else begin
         tx_byte = present[r[2:0]];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         link.rsp_valid <= 1'b0;
         link.rsp_data <= 8'h00;
         link.rsp_last <= 1'b0;
      end else begin
         link.rsp_valid <= state == sse_pkg::SSE_T_TX;
         link.rsp_data <= state == sse_pkg::SSE_T_TX ? tx_byte : 8'h00;
         link.rsp_last <= state == sse_pkg::SSE_T_TX &&
                          tx_idx == tx_len - 5'h01;
      end
   end
endmodule

// *** sse_params.svh ***
`ifndef SSE_PARAMS_SVH
`define SSE_PARAMS_SVH
`define SSE_CMD_SET 8'h01
`define SSE_CMD_GET 8'h02
`define SSE_HDL_RSVD_LO 16'h0000
`define SSE_HDL_RSVD_HI 16'hffff
`define SSE_HDL_OWN 16'h0001
`define SSE_CNT_MIN 8'h01
`define SSE_CNT_MAX 8'h08
`define SSE_EFF_NUM 8
`define SSE_CC_SUCCESS 8'h00
`define SSE_CC_INV_DATA 8'h02
`define SSE_CC_BAD_CMD 8'h05
`define SSE_CC_INV_ID 8'h80
`define SSE_CC_INV_STATE 8'h81
`define SSE_CC_UNSUP_STATE 8'h82
`define SSE_SR_NO_CHANGE 8'h00
`define SSE_SR_REQ_SET 8'h01
`define SSE_ST_UNKNOWN 8'h00
`define SSE_ST_MIN 8'h01
`define SSE_ST_MAX 8'h04
`define SSE_ST_RESET 8'h01
`define SSE_UPD_NS 100
`define SSE_CLK_MHZ 125
`define SSE_UPD_CYC ((`SSE_UPD_NS * `SSE_CLK_MHZ + 999) / 1000)
`define SSE_RX_MAX 20
`define SSE_GET_RSP_LEN 26
`define SSE_REG_CTRL 8'h00
`define SSE_REG_HANDLE 8'h04
`define SSE_REG_COUNT 8'h08
`define SSE_REG_STATUS 8'h0c
`define SSE_REG_INT_STAT 8'h10
`define SSE_REG_INT_MASK 8'h14
`define SSE_REG_REC_BASE 8'h40
`define SSE_REG_RSP_BASE 8'h60
`endif

// *** sse_pkg.sv ***
package sse_pkg;
   typedef enum logic [7:0] {
      SSE_OP_UPD_PEND = 8'h00,
      SSE_OP_NO_UPD = 8'h01,
      SSE_OP_DISABLED = 8'h02,
      SSE_OP_UNAVAIL = 8'h03
   } sse_op_t;
   typedef enum logic [3:0] {
      SSE_T_IDLE = 4'b0001,
      SSE_T_RX = 4'b0010,
      SSE_T_EVAL = 4'b0100,
      SSE_T_TX = 4'b1000
   } sse_tstate_t;
   typedef enum logic [2:0] {
      SSE_H_IDLE = 3'b001,
      SSE_H_SEND = 3'b010,
      SSE_H_WAIT = 3'b100
   } sse_hstate_t;
endpackage

// *** sse_link_if.sv ***
`timescale 1ns/1ps
interface sse_link_if;
   logic req_valid;
   logic [7:0] req_data;
   logic req_last;
   logic rsp_valid;
   logic [7:0] rsp_data;
   logic rsp_last;
   modport term (
      input req_valid,
      input req_data,
      input req_last,
      output rsp_valid,
      output rsp_data,
      output rsp_last
   );
   modport req (
      output req_valid,
      output req_data,
      output req_last,
      input rsp_valid,
      input rsp_data,
      input rsp_last
   );
endinterface

// *** sse_requester.sv ***
`timescale 1ns/1ps
`include "sse_params.svh"
module sse_requester (
   input wire logic clk,
   input wire logic rst_n,
   sse_link_if.req link,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic irq
);
   // ------
   // Register file
   // ------
   sse_pkg::sse_hstate_t state;
   logic cmd_get;
   logic [15:0] handle;
   logic [7:0] count;
   logic [15:0] rec [0:7];
   logic [23:0] rsp_rec [0:7];
   logic [7:0] cc;
   logic [7:0] rsp_cnt;
   logic [1:0] int_stat;
   logic [1:0] int_mask;
   logic ap_wr;
   logic [7:0] ap_addr;
   logic [4:0] idx;
   logic [4:0] len;
   logic start;
   logic refuse;
   logic done_ev;
   logic err_ev;

   function automatic logic in_win(input logic [7:0] a,
      input logic [7:0] base);
      return a[7:5] == base[7:5];
   endfunction

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hreadyout <= 1'b0;
         hresp <= 1'b0;
         ap_wr <= 1'b0;
         ap_addr <= 8'h00;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         ap_wr <= hsel && htrans[1] && hready && hwrite && hsize == 3'h2;
         ap_addr <= haddr[7:0];
      end
   end

   assign start = ap_wr && ap_addr == `SSE_REG_CTRL && hwdata[0] &&
                  state == sse_pkg::SSE_H_IDLE;
   // Reserved handles and counts out of range never leave this end.
   assign refuse = handle == `SSE_HDL_RSVD_LO ||
                   handle == `SSE_HDL_RSVD_HI ||
                   (!hwdata[1] && (count < `SSE_CNT_MIN ||
                                 count > `SSE_CNT_MAX)); // R1 R2

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_get <= 1'b0;
         handle <= 16'h0001;
         count <= 8'h01;
         int_mask <= 2'h0;
         for (int i = 0; i < 8; i++) begin
            rec[i] <= 16'h0000;
         end
      end else if (ap_wr && state == sse_pkg::SSE_H_IDLE) begin
         if (ap_addr == `SSE_REG_CTRL) begin
            cmd_get <= hwdata[1];
         end else if (ap_addr == `SSE_REG_HANDLE) begin
            handle <= hwdata[15:0];
         end else if (ap_addr == `SSE_REG_COUNT) begin
            count <= hwdata[7:0];
         end else if (ap_addr == `SSE_REG_INT_MASK) begin
            int_mask <= hwdata[1:0];
         end else if (in_win(ap_addr, `SSE_REG_REC_BASE)) begin
            rec[ap_addr[4:2]] <= hwdata[15:0]; // R16
         end
      end else if (ap_wr && ap_addr == `SSE_REG_INT_MASK) begin
         int_mask <= hwdata[1:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= 32'h00000000;
      end else if (hsel && htrans[1] && hready && !hwrite) begin
         if (haddr[7:0] == `SSE_REG_CTRL) begin
            hrdata <= {30'h0, cmd_get, 1'b0};
         end else if (haddr[7:0] == `SSE_REG_HANDLE) begin
            hrdata <= {16'h0000, handle};
         end else if (haddr[7:0] == `SSE_REG_COUNT) begin
            hrdata <= {24'h000000, count};
         end else if (haddr[7:0] == `SSE_REG_STATUS) begin
            hrdata <= {8'h00, rsp_cnt, cc, 7'h00,
                       state != sse_pkg::SSE_H_IDLE};
         end else if (haddr[7:0] == `SSE_REG_INT_STAT) begin
            hrdata <= {30'h0, int_stat};
         end else if (haddr[7:0] == `SSE_REG_INT_MASK) begin
            hrdata <= {30'h0, int_mask};
         end else if (in_win(haddr[7:0], `SSE_REG_REC_BASE)) begin
            hrdata <= {16'h0000, rec[haddr[4:2]]};
         end else if (in_win(haddr[7:0], `SSE_REG_RSP_BASE)) begin
            hrdata <= {8'h00, rsp_rec[haddr[4:2]]};
         end else begin
            hrdata <= 32'h00000000;
         end
      end
   end

   // ------
   // Interrupts
   // ------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         int_stat <= 2'h0;
         irq <= 1'b0;
      end else begin
         // A read clears, but an event in the same cycle still lands.
         int_stat <= ((hsel && htrans[1] && hready && !hwrite &&
                       haddr[7:0] == `SSE_REG_INT_STAT) ? 2'h0 : int_stat)
                     | {err_ev, done_ev};
         irq <= |(int_stat & int_mask);
      end
   end

   // ------
   // Link sequence
   // ------
   logic [7:0] tx_byte;

   always_comb begin
      logic [15:0] r;
      r = rec[3'((idx - 5'd4) >> 1)];
      unique case (idx)
         5'd0: tx_byte = cmd_get ? `SSE_CMD_GET : `SSE_CMD_SET;
         5'd1: tx_byte = handle[7:0];
         5'd2: tx_byte = handle[15:8];
         5'd3: tx_byte = count;
         default: tx_byte = idx[0] ? r[15:8] : r[7:0]; // R3
      endcase
   end

   assign done_ev = state == sse_pkg::SSE_H_WAIT && link.rsp_valid &&
                    link.rsp_last;
   assign err_ev = (start && refuse) || (done_ev && cc != `SSE_CC_SUCCESS &&
                   idx != 5'd0) || (done_ev && idx == 5'd0 &&
                   link.rsp_data != `SSE_CC_SUCCESS);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= sse_pkg::SSE_H_IDLE;
         idx <= 5'h00;
         len <= 5'h00;
         cc <= 8'h00;
         rsp_cnt <= 8'h00;
         link.req_valid <= 1'b0;
         link.req_data <= 8'h00;
         link.req_last <= 1'b0;
         for (int i = 0; i < 8; i++) begin
            rsp_rec[i] <= 24'h000000;
         end
      end else begin
         link.req_valid <= 1'b0;
         link.req_last <= 1'b0;
         unique case (state)
            sse_pkg::SSE_H_IDLE: begin
               if (start && !refuse) begin
                  idx <= 5'h00;
                  len <= hwdata[1] ? 5'd3 : 5'(5'd4 + {count[3:0], 1'b0});
                  rsp_cnt <= 8'h00;
                  state <= sse_pkg::SSE_H_SEND;
               end
            end
            sse_pkg::SSE_H_SEND: begin
               link.req_valid <= 1'b1;
               link.req_data <= tx_byte; // R10
               link.req_last <= idx == len - 5'h01;
               idx <= idx + 5'h01;
               if (idx == len - 5'h01) begin
                  idx <= 5'h00;
                  state <= sse_pkg::SSE_H_WAIT;
               end
            end
            sse_pkg::SSE_H_WAIT: begin
               if (link.rsp_valid) begin
                  idx <= idx + 5'h01;
                  if (idx == 5'd0) begin
                     cc <= link.rsp_data;
                  end else if (idx == 5'd1) begin
                     rsp_cnt <= link.rsp_data;
                  end else begin
                     rsp_rec[3'((idx - 5'd2) / 5'd3)]
                        [8 * ((idx - 5'd2) % 5'd3) +: 8] <= link.rsp_data;
                  end
                  if (link.rsp_last) begin
                     state <= sse_pkg::SSE_H_IDLE;
                  end
               end
            end
         endcase
      end
   end
endmodule

// *** sse_link_properties.sv ***
`timescale 1ns/1ps
`include "sse_params.svh"
module sse_link_properties (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire logic [7:0] req_data,
   input wire logic req_last,
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_data,
   input wire logic rsp_last
);
   logic [7:0] pos;
   logic [7:0] cmd;
   logic [7:0] hlo;
   logic [7:0] hhi;
   logic [7:0] cnt;
   logic busy;
   logic head;
   logic get_end;
   logic [15:0] get_hdl;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ------
   // Request tracking
   // ------
   assign get_end = req_valid && req_last && pos == 8'h02
      && cmd == `SSE_CMD_GET;
   assign get_hdl = {req_data, hlo};
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pos <= 8'h00;
      end else if (req_valid) begin
         pos <= req_last ? 8'h00 : pos + 8'h01;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd <= 8'h00;
         hlo <= 8'h00;
         hhi <= 8'h00;
         cnt <= 8'h00;
      end else if (req_valid) begin
         if (pos == 8'h00) cmd <= req_data;
         if (pos == 8'h01) hlo <= req_data;
         if (pos == 8'h02) hhi <= req_data;
         if (pos == 8'h03) cnt <= req_data;
      end
   end
   // Head marks the first answer byte, which alone carries the code.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy <= 1'b0;
         head <= 1'b0;
      end else begin
         if (req_valid && req_last) busy <= 1'b1;
         else if (rsp_valid && rsp_last) busy <= 1'b0;
         if (req_valid && req_last) head <= 1'b1;
         else if (rsp_valid) head <= 1'b0;
      end
   end
   // ------
   // Properties
   // ------
   a_rsp_three_late: assert property (req_valid && req_last |->
      ##1 !rsp_valid ##1 !rsp_valid ##1 rsp_valid)
      else $error("late answer");
   a_get_bad_id: assert property (get_end && get_hdl != `SSE_HDL_OWN
      |-> ##3 rsp_data == `SSE_CC_INV_ID && rsp_last)
      else $error("get id not refused");
   a_get_ok_head: assert property (get_end && get_hdl == `SSE_HDL_OWN
      |-> ##3 rsp_data == `SSE_CC_SUCCESS ##1 rsp_data == `SSE_CNT_MAX)
      else $error("get answer head wrong");
   a_get_ok_len: assert property (get_end && get_hdl == `SSE_HDL_OWN
      |-> ##28 rsp_valid && rsp_last)
      else $error("get answer length wrong");
   a_set_bad_id: assert property (req_valid && req_last && pos > 8'h04
      && cmd == `SSE_CMD_SET && {hhi, hlo} != `SSE_HDL_OWN
      |-> ##3 rsp_data == `SSE_CC_INV_ID && rsp_last)
      else $error("set id not refused");
   a_no_rsvd_hdl: assert property (req_valid && pos == 8'h02
      |-> !(get_hdl inside {16'h0000, 16'hffff}))
      else $error("reserved handle sent");
   a_set_count_ok: assert property (req_valid && pos == 8'h03
      && cmd == `SSE_CMD_SET
      |-> req_data inside {[`SSE_CNT_MIN:`SSE_CNT_MAX]})
      else $error("set count out of range");
   a_set_rec_len: assert property (req_valid && req_last
      && cmd == `SSE_CMD_SET && pos > 8'h03 |-> pos == cnt + cnt + 8'h03)
      else $error("set record count mismatch");
   a_get_no_count: assert property (req_valid && req_last
      && cmd == `SSE_CMD_GET && pos != 8'h00 |-> pos == 8'h02)
      else $error("get request too long");
   a_err_one_byte: assert property (rsp_valid && head
      && rsp_data != `SSE_CC_SUCCESS |-> rsp_last)
      else $error("long error answer");
   a_one_request: assert property (busy |-> !req_valid)
      else $error("overlapping request");
endmodule

// *** tb_state_effecter_set_get_handler.sv ***
`timescale 1ns/1ps
`include "sse_params.svh"
module tb_state_effecter_set_get_handler;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [7:0] eff_disable = 8'h00;
   logic [7:0] eff_unavail = 8'h00;
   logic [31:0] hrdata;
   logic hreadyout;
   logic irq;
   logic [63:0] eff_present;
   logic [7:0] pend;
   logic [63:0] pres;
   logic [31:0] rd;
   int error_cnt = 0;
   int samples_checked = 0;
   sse_link_if sse_link_if_i ();
   sse_terminus sse_terminus_i (.clk(clk), .rst_n(rst_n),
      .link(sse_link_if_i), .eff_disable(eff_disable),
      .eff_unavail(eff_unavail), .eff_present(eff_present),
      .eff_pending(pend), .eff_apply());
   sse_requester sse_requester_i (.clk(clk), .rst_n(rst_n),
      .link(sse_link_if_i), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .irq(irq));
   sse_link_properties sse_link_properties_i (.clk(clk), .rst_n(rst_n),
      .req_valid(sse_link_if_i.req_valid), .req_data(sse_link_if_i.req_data),
      .req_last(sse_link_if_i.req_last), .rsp_valid(sse_link_if_i.rsp_valid),
      .rsp_data(sse_link_if_i.rsp_data), .rsp_last(sse_link_if_i.rsp_last));
   always #4 clk = ~clk;
   // ------
   // Bus tasks
   // ------
   task finish_test;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task chk(input logic [63:0] got, input logic [63:0] exp, input string s);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t %s got %h exp %h", $time, s, got, exp);
      end
   endtask
   task wait_rdy;
      int n;
      n = 0;
      @(posedge clk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 50) begin
            error_cnt++;
            $display("[FAIL] %0t bus hang", $time);
            finish_test;
         end
         @(posedge clk);
      end
   endtask
   // Address phase, then data phase, each held until hready.
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
      rd = hrdata;
   endtask
   // Polls busy; a refused start never raises it.
   task run(input logic cmd, input logic [15:0] h);
      int n;
      ahb(1'b1, `SSE_REG_HANDLE, {16'h0, h});
      ahb(1'b1, `SSE_REG_CTRL, {30'h0, cmd, 1'b1});
      n = 0;
      ahb(1'b0, `SSE_REG_STATUS, 32'h0);
      while (rd[0] !== 1'b0) begin
         n++;
         if (n > 100) begin
            error_cnt++;
            $display("[FAIL] %0t command hang", $time);
            finish_test;
         end
         ahb(1'b0, `SSE_REG_STATUS, 32'h0);
      end
   endtask
   // ------
   // Tests
   // ------
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      ahb(1'b0, `SSE_REG_HANDLE, 32'h0);
      chk(64'(rd), 64'h1, "handle reset");
      ahb(1'b0, 8'h3c, 32'h0);
      chk(64'(rd), 64'h0, "unmapped read");
      pres = {8{8'h01}};
      chk(eff_present, pres, "present reset");
      run(1'b1, `SSE_HDL_OWN);
      chk(64'(rd[23:8]), 64'h0800, "get count");
      for (int i = 0; i < 8; i++) begin
         ahb(1'b0, 8'(`SSE_REG_RSP_BASE + 4 * i), 32'h0);
         chk(64'(rd), 64'h010101, "reset record");
      end
      $display("test reset and get done");
      ahb(1'b1, `SSE_REG_COUNT, 32'h8);
      for (int i = 0; i < 8; i++) begin
         if (i % 2 == 1) begin
            ahb(1'b1, 8'(`SSE_REG_REC_BASE + 4 * i), 32'h0000ee00);
         end else begin
            pres[8 * i +: 8] = (i % 4 == 0) ? 8'h04 : 8'h02;
            ahb(1'b1, 8'(`SSE_REG_REC_BASE + 4 * i),
               {16'h0, pres[8 * i +: 8], 8'h01});
         end
      end
      run(1'b0, `SSE_HDL_OWN);
      chk(64'(rd[15:8]), 64'h0, "set code");
      chk(64'(pend), 64'h55, "pending");
      repeat (20) @(posedge clk);
      chk(eff_present, pres, "present after set");
      run(1'b1, `SSE_HDL_OWN);
      for (int i = 0; i < 8; i++) begin
         ahb(1'b0, 8'(`SSE_REG_RSP_BASE + 4 * i), 32'h0);
         chk(64'(rd), 64'({pres[8 * i +: 8], pres[8 * i +: 8], 8'h01}),
            "record after set");
      end
      $display("test set all offsets done");
      ahb(1'b1, `SSE_REG_COUNT, 32'h1);
      for (int k = 0; k < 3; k++) begin
         ahb(1'b1, `SSE_REG_REC_BASE,
            (k == 2) ? 32'h0202 : 32'h0501 - k * 32'h0500);
         run(1'b0, `SSE_HDL_OWN);
         chk(64'(rd[15:8]), (k == 2) ? 64'h02 : 64'h81, "bad record");
      end
      chk(eff_present, pres, "present kept");
      chk(64'(irq), 64'h0, "irq masked");
      ahb(1'b1, `SSE_REG_INT_MASK, 32'h2);
      repeat (2) @(posedge clk);
      chk(64'(irq), 64'h1, "irq raised");
      ahb(1'b0, `SSE_REG_INT_STAT, 32'h0);
      chk(64'(rd[1]), 64'h1, "error event");
      repeat (2) @(posedge clk);
      chk(64'(irq), 64'h0, "irq cleared");
      $display("test refused records done");
      eff_disable <= 8'h01;
      eff_unavail <= 8'h02;
      ahb(1'b1, `SSE_REG_REC_BASE, 32'h0301);
      run(1'b0, `SSE_HDL_OWN);
      chk(64'(rd[15:8]), 64'h82, "disabled target");
      chk(eff_present, pres, "disabled kept");
      run(1'b1, `SSE_HDL_OWN);
      ahb(1'b0, `SSE_REG_RSP_BASE, 32'h0);
      chk(64'(rd), 64'h2, "disabled record");
      ahb(1'b0, 8'(`SSE_REG_RSP_BASE + 4), 32'h0);
      chk(64'(rd), 64'h3, "unavailable record");
      eff_disable <= 8'h00;
      eff_unavail <= 8'h00;
      $display("test disabled effecters done");
      run(1'b0, 16'h0002);
      chk(64'(rd[15:8]), 64'h80, "foreign set");
      run(1'b1, 16'h0002);
      chk(64'(rd[15:8]), 64'h80, "foreign get");
      ahb(1'b0, `SSE_REG_INT_STAT, 32'h0);
      run(1'b1, 16'hffff);
      ahb(1'b0, `SSE_REG_INT_STAT, 32'h0);
      chk(64'(rd[1]), 64'h1, "reserved handle");
      ahb(1'b1, `SSE_REG_COUNT, 32'h9);
      run(1'b0, `SSE_HDL_OWN);
      ahb(1'b0, `SSE_REG_INT_STAT, 32'h0);
      chk(64'(rd[1]), 64'h1, "count too large");
      $display("test handles and counts done");
      finish_test;
   end
endmodule
